// file: hdl/sdm_pkg.sv
// sdm_pkg: constants and carrier types for the serial data path and fault logic
// assumes a byte-wide register port and one 200 MHz clock
package sdm_pkg;

	// register byte addresses
	localparam logic [7:0] ADDR_DATA_IO  = 8'h21;
	localparam logic [7:0] ADDR_CONTROL  = 8'h22;
	localparam logic [7:0] ADDR_STATUS   = 8'h23;
	localparam logic [7:0] ADDR_EVT_STAT = 8'h24;
	localparam logic [7:0] ADDR_EVT_MASK = 8'h25;

	// control register fields
	localparam int CTL_IRQ_EN   = 7;
	localparam int CTL_PIN_OE   = 6;
	localparam int CTL_DIV_SEL  = 5;
	localparam int CTL_MASTER   = 4;
	localparam int CTL_CPOL     = 3;
	localparam int CTL_CPHA     = 2;
	localparam int CTL_RATE_HI  = 1;
	localparam int CTL_RATE_LO  = 0;
	localparam logic [3:0] CTL_UPPER_RST = 4'h0;

	// status register fields
	localparam int STS_DONE      = 7;
	localparam int STS_COLLISION = 6;
	localparam int STS_FAULT     = 4;
	localparam logic [3:0] STS_UNUSED_VAL = 4'h0;

	// event register fields
	localparam int EVT_DONE      = 0;
	localparam int EVT_FAULT     = 1;
	localparam int EVT_COLLISION = 2;
	localparam int EVT_W         = 3;
	localparam logic [EVT_W-1:0] EVT_RST = 3'h0;

	// serial clock half periods in clk cycles, minus one
	localparam logic [5:0] HALF_DIV4   = 6'h01;
	localparam logic [5:0] HALF_DIV8   = 6'h03;
	localparam logic [5:0] HALF_DIV16  = 6'h07;
	localparam logic [5:0] HALF_DIV32  = 6'h0f;
	localparam logic [5:0] HALF_DIV64  = 6'h1f;
	localparam logic [5:0] HALF_DIV128 = 6'h3f;

	// one byte is sixteen serial clock edges
	localparam logic [4:0] EDGE_LAST = 5'h0f;
	localparam int SYNC_W = 4;

	// register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} sdm_req_t;

	// serial pins, input direction only
	typedef struct packed {
		logic sck;
		logic mosi;
		logic miso;
		logic sel_n;
	} sdm_pin_in_t;

endpackage

// file: hdl/sdm_core.sv
// sdm_core: byte shifter, data buffer, mode fault and flag logic of a serial port
// assumes register strobes come from logic on clk; pins arrive unsynchronised
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps

// Operation
// - serial select low while master sets the fault flag, status bit 4.
// - fault flag with interrupt enable set raises the interrupt request.
// - fault flag clears only after status read with flag set, then control write.
// - master starts shifting a byte only on a data register write.
// - last cycle of a transfer copies shift register to buffer, sets done flag.
// - data register reads return the receive buffer, not the shifter.
// - data register writes load the shifter directly, no transmit buffer.
// - reset clears control bits 7 to 4; bits 3 to 0 stay undefined.
// - a mode fault also clears pin enable and master select.
// - data register writes are ignored while the done flag is set, unless a status read armed its clear.
// - data register write during a transfer sets the collision flag.
module sdm_core (
	input  wire logic                clk,
	input  wire logic                sys_rst,
	input  wire sdm_pkg::sdm_req_t   req,
	output logic [7:0]               rdata,
	output logic                     irq,
	input  wire sdm_pkg::sdm_pin_in_t pin_in,
	output logic                     sck_o,
	output logic                     sck_oe,
	output logic                     mosi_o,
	output logic                     mosi_oe,
	output logic                     miso_o,
	output logic                     miso_oe
);

	// serial half period from the rate bits
	function automatic logic [5:0] half_term(input logic [2:0] sel);
		case (sel)
			3'h4:    half_term = sdm_pkg::HALF_DIV4;
			3'h0:    half_term = sdm_pkg::HALF_DIV8;
			3'h1:    half_term = sdm_pkg::HALF_DIV16;
			3'h6:    half_term = sdm_pkg::HALF_DIV32;
			3'h2:    half_term = sdm_pkg::HALF_DIV64;
			3'h3:    half_term = sdm_pkg::HALF_DIV128;
			default: half_term = sdm_pkg::HALF_DIV128;
		endcase
	endfunction

	logic [sdm_pkg::SYNC_W-1:0] meta_q;
	logic [sdm_pkg::SYNC_W-1:0] sync_q;
	logic [3:0]                 ctl_hi_q;
	logic [3:0]                 ctl_lo_q;
	logic                       done_q;
	logic                       coll_q;
	logic                       fault_q;
	logic                       done_armed_q;
	logic                       fault_armed_q;
	logic [sdm_pkg::EVT_W-1:0]  evt_q;
	logic [sdm_pkg::EVT_W-1:0]  mask_q;
	logic [7:0]                 shift_q;
	logic [7:0]                 rxbuf_q;
	logic                       rxbit_q;
	logic                       run_q;
	logic [5:0]                 div_q;
	logic [4:0]                 edge_q;
	logic                       sck_q;
	logic                       sck_prev_q;
	logic [7:0]                 rdata_q;
	logic                       irq_q;
	logic                       sck_oe_q;
	logic                       mosi_oe_q;
	logic                       miso_oe_q;

	logic sck_s;
	logic din_s;
	logic rx_bit;
	logic sel_n_s;
	logic is_master;
	logic pin_en;
	logic cpol;
	logic wr_data;
	logic rd_data;
	logic wr_ctl;
	logic rd_stat;
	logic busy;
	logic data_ok;
	logic start;
	logic m_tick;
	logic s_edge;
	logic ev_edge;
	logic ev_lead;
	logic ev_trail;
	logic ev_last;
	logic fault_ev;
	logic coll_ev;
	logic done_clr;
	logic fault_clr;

	// two-stage synchroniser on every pin input
	genvar gi;
	generate
		for (gi = 0; gi < sdm_pkg::SYNC_W; gi++) begin : g_sync
			always_ff @(posedge clk or posedge sys_rst) begin
				// select resets to its idle high level, so no false fault follows reset
				if (sys_rst) begin
					meta_q[gi] <= (gi == 0) ? 1'b1 : 1'b0;
					sync_q[gi] <= (gi == 0) ? 1'b1 : 1'b0;
				end else begin
					meta_q[gi] <= pin_in[gi];
					sync_q[gi] <= meta_q[gi];
				end
			end
		end
	endgenerate

	// synchronised pins; sel_n reads low only after a real low level
	assign sck_s     = sync_q[3];
	assign din_s     = is_master ? sync_q[1] : sync_q[2];
	assign sel_n_s   = sync_q[0];
	assign is_master = ctl_hi_q[sdm_pkg::CTL_MASTER - 4];
	assign pin_en    = ctl_hi_q[sdm_pkg::CTL_PIN_OE - 4];
	assign cpol      = ctl_lo_q[sdm_pkg::CTL_CPOL];
	// master takes its input at the trailing edge: sync delay eats a /4 half period
	assign rx_bit    = is_master ? din_s : rxbit_q;

	// register port decode
	assign wr_data = req.wr && (req.addr == sdm_pkg::ADDR_DATA_IO);
	assign rd_data = req.rd && (req.addr == sdm_pkg::ADDR_DATA_IO);
	assign wr_ctl  = req.wr && (req.addr == sdm_pkg::ADDR_CONTROL);
	assign rd_stat = req.rd && (req.addr == sdm_pkg::ADDR_STATUS);

	// a slave is busy from its first edge until the byte ends
	assign busy     = run_q || (edge_q != 5'h00);
	// the clearing access itself is accepted, a plain write under done is not
	assign data_ok  = !done_q || done_armed_q;
	assign coll_ev  = wr_data && busy;
	assign start    = wr_data && data_ok && !busy && is_master && pin_en;
	assign fault_ev = is_master && !sel_n_s;

	// serial clock events: master divider or sampled slave clock
	assign m_tick   = run_q && (div_q == half_term({ctl_hi_q[1], ctl_lo_q[1:0]}));
	assign s_edge   = !is_master && pin_en && !sel_n_s && (sck_s != sck_prev_q);
	assign ev_edge  = m_tick || s_edge;
	assign ev_lead  = ev_edge && !edge_q[0];
	assign ev_trail = ev_edge && edge_q[0];
	assign ev_last  = ev_trail && (edge_q == sdm_pkg::EDGE_LAST);

	// clear sequences complete on the second access
	assign done_clr  = done_armed_q && (rd_data || wr_data);
	assign fault_clr = fault_armed_q && wr_ctl;

	// control register: upper half reset, lower half left undefined
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctl_hi_q <= sdm_pkg::CTL_UPPER_RST;
		end else if (fault_ev) begin
			// fault drops pin drive and falls back to slave, outranking writes
			ctl_hi_q[sdm_pkg::CTL_PIN_OE - 4] <= 1'b0;
			ctl_hi_q[sdm_pkg::CTL_MASTER - 4] <= 1'b0;
			if (wr_ctl) begin
				ctl_hi_q[sdm_pkg::CTL_IRQ_EN - 4]  <= req.wdata[sdm_pkg::CTL_IRQ_EN];
				ctl_hi_q[sdm_pkg::CTL_DIV_SEL - 4] <= req.wdata[sdm_pkg::CTL_DIV_SEL];
			end
		end else if (wr_ctl) begin
			ctl_hi_q <= req.wdata[7:4];
		end
	end

	// lower control bits carry no reset on purpose
	always_ff @(posedge clk) begin
		if (wr_ctl) begin
			ctl_lo_q <= req.wdata[3:0];
		end
	end

	// mode fault flag and its clear sequence; a new fault beats the clear
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fault_q       <= 1'b0;
			fault_armed_q <= 1'b0;
		end else begin
			if (fault_ev) begin
				fault_q <= 1'b1;
			end else if (fault_clr) begin
				fault_q <= 1'b0;
			end
			if (fault_clr || fault_ev) begin
				fault_armed_q <= 1'b0;
			end else if (rd_stat && fault_q) begin
				fault_armed_q <= 1'b1;
			end
		end
	end

	// done and collision flags, cleared by status read then data access
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			done_q       <= 1'b0;
			coll_q       <= 1'b0;
			done_armed_q <= 1'b0;
		end else begin
			if (ev_last) begin
				done_q <= 1'b1;
			end else if (done_clr) begin
				done_q <= 1'b0;
			end
			if (coll_ev) begin
				coll_q <= 1'b1;
			end else if (done_clr) begin
				coll_q <= 1'b0;
			end
			if (done_clr || ev_last || coll_ev) begin
				done_armed_q <= 1'b0;
			end else if (rd_stat && (done_q || coll_q)) begin
				done_armed_q <= 1'b1;
			end
		end
	end

	// sticky events, write one to clear; set wins over a same-cycle clear
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			evt_q  <= sdm_pkg::EVT_RST;
			mask_q <= sdm_pkg::EVT_RST;
		end else begin
			if (req.wr && (req.addr == sdm_pkg::ADDR_EVT_MASK)) begin
				mask_q <= req.wdata[sdm_pkg::EVT_W-1:0];
			end
			evt_q <= (evt_q & ~((req.wr && (req.addr == sdm_pkg::ADDR_EVT_STAT))
				? req.wdata[sdm_pkg::EVT_W-1:0] : sdm_pkg::EVT_RST))
				| {coll_ev, fault_ev, ev_last};
		end
	end

	// interrupt level: documented flag path or the masked event path
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= (ctl_hi_q[sdm_pkg::CTL_IRQ_EN - 4] && (fault_q || done_q))
				|| (|(evt_q & mask_q));
		end
	end

	// master sequencer: divider, edge count and serial clock level
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			run_q  <= 1'b0;
			div_q  <= 6'h00;
			edge_q <= 5'h00;
			sck_q  <= 1'b0;
		end else if (fault_ev || (!is_master && sel_n_s)) begin
			// fault aborts the master; a deselected slave restarts its count
			run_q  <= 1'b0;
			div_q  <= 6'h00;
			edge_q <= 5'h00;
			sck_q  <= cpol;
		end else if (start) begin
			run_q  <= 1'b1;
			div_q  <= 6'h00;
			edge_q <= 5'h00;
			sck_q  <= cpol;
		end else begin
			if (run_q) begin
				div_q <= m_tick ? 6'h00 : div_q + 6'h01;
			end else begin
				sck_q <= cpol;
			end
			if (m_tick) begin
				sck_q <= !sck_q;
			end
			if (ev_last) begin
				run_q  <= 1'b0;
				edge_q <= 5'h00;
			end else if (ev_edge) begin
				edge_q <= edge_q + 5'h01;
			end
		end
	end

	// previous slave clock level for edge finding
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sck_prev_q <= 1'b0;
		end else begin
			sck_prev_q <= sck_s;
		end
	end

	// shifter: slave samples on leading edge, both shift on trailing edge
	always_ff @(posedge clk) begin
		if (wr_data && data_ok && !busy) begin
			shift_q <= req.wdata;
		end else if (ev_trail) begin
			shift_q <= {shift_q[6:0], rx_bit};
		end
		if (ev_lead) begin
			rxbit_q <= din_s;
		end
	end

	// receive buffer loads in the same cycle the done flag sets
	always_ff @(posedge clk) begin
		if (ev_last) begin
			rxbuf_q <= {shift_q[6:0], rx_bit};
		end
	end

	// read data, valid the cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_q <= 8'h00;
		end else if (req.rd) begin
			case (req.addr)
				sdm_pkg::ADDR_DATA_IO:  rdata_q <= rxbuf_q;
				sdm_pkg::ADDR_CONTROL:  rdata_q <= {ctl_hi_q, ctl_lo_q};
				sdm_pkg::ADDR_STATUS:   rdata_q <= {done_q, coll_q, 1'b0, fault_q,
					sdm_pkg::STS_UNUSED_VAL};
				sdm_pkg::ADDR_EVT_STAT: rdata_q <= {5'h00, evt_q};
				sdm_pkg::ADDR_EVT_MASK: rdata_q <= {5'h00, mask_q};
				default:                rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	// pin enables follow the registered mode
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sck_oe_q  <= 1'b0;
			mosi_oe_q <= 1'b0;
			miso_oe_q <= 1'b0;
		end else begin
			sck_oe_q  <= pin_en && is_master && !fault_ev;
			mosi_oe_q <= pin_en && is_master && !fault_ev;
			miso_oe_q <= pin_en && !is_master && !sel_n_s;
		end
	end

	assign rdata   = rdata_q;
	assign irq     = irq_q;
	assign sck_o   = sck_q;
	assign sck_oe  = sck_oe_q;
	assign mosi_o  = shift_q[7];
	assign mosi_oe = mosi_oe_q;
	assign miso_o  = shift_q[7];
	assign miso_oe = miso_oe_q;

endmodule

// file: dv/sdm_core_chk.sv
// sdm_core_chk: port assertions for sdm_core
// assumes CPOL stays 0 and requests keep the register port contract
`timescale 1ns/1ps
module sdm_core_chk (
	input wire logic                 clk,
	input wire logic                 sys_rst,
	input wire sdm_pkg::sdm_req_t    req,
	input wire logic [7:0]           rdata,
	input wire logic                 irq,
	input wire sdm_pkg::sdm_pin_in_t pin_in,
	input wire logic                 sck_o,
	input wire logic                 sck_oe,
	input wire logic                 mosi_o,
	input wire logic                 mosi_oe,
	input wire logic                 miso_o,
	input wire logic                 miso_oe
);
	logic       sts_q, crd_q, seen_q, ie_q, flt_q, wctl_q;
	logic [4:0] edge_q;
	logic       cwr;
	assign cwr = req.wr && req.addr == sdm_pkg::ADDR_CONTROL;
	// shadows of reads, control writes and serial clock toggles
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			{sts_q, crd_q, seen_q, ie_q, flt_q, wctl_q} <= 6'h00;
			edge_q <= 5'h00;
		end else begin
			sts_q <= req.rd && req.addr == sdm_pkg::ADDR_STATUS;
			crd_q <= req.rd && req.addr == sdm_pkg::ADDR_CONTROL;
			seen_q <= seen_q | cwr;
			if (cwr) ie_q <= req.wdata[7];
			if (sts_q) flt_q <= rdata[4];
			// a clearing write only counts once a fault was read
			wctl_q <= cwr ? (wctl_q | flt_q | (sts_q & rdata[4])) : (!sts_q & wctl_q);
			if (req.wr && req.addr == sdm_pkg::ADDR_DATA_IO) edge_q <= 5'h00;
			else if (sck_oe && $changed(sck_o) && edge_q != 5'h1f) edge_q <= edge_q + 5'h01;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	unused_bits_a: assert property (sts_q |-> rdata[3:0] == 4'h0 && !rdata[5])
		else $error("unused status bits not zero");
	ctl_reset_a: assert property (crd_q && !seen_q |-> rdata[7:4] == 4'h0)
		else $error("control upper bits not cleared by reset");
	fault_abort_a: assert property (!pin_in.sel_n [*5] |-> !mosi_oe && !sck_oe)
		else $error("pins still driven after select went low");
	fault_irq_a: assert property (sts_q && rdata[4] && ie_q |-> irq)
		else $error("fault without interrupt");
	done_irq_a: assert property (sts_q && rdata[7] && ie_q |-> irq)
		else $error("done without interrupt");
	edge_budget_a: assert property (sck_oe && $changed(sck_o) |-> edge_q < 5'h10)
		else $error("serial clock runs without a data write");
	mosi_edge_a: assert property (mosi_oe && $past(mosi_oe) && $changed(mosi_o) |-> !sck_o)
		else $error("data out changed on a leading edge");
	fault_clear_a: assert property (sts_q && !rdata[4] && flt_q |-> wctl_q)
		else $error("fault cleared without control write");
endmodule
bind sdm_core sdm_core_chk u_sdm_core_chk (.clk, .sys_rst, .req, .rdata, .irq, .pin_in,
	.sck_o, .sck_oe, .mosi_o, .mosi_oe, .miso_o, .miso_oe);

// file: dv/sdm_slave_model.sv
// sdm_slave_model: serial slave on the far side, phase 0, MSB first
// assumes its clock idles low; fault pulls select low and restarts its count
`timescale 1ns/1ps
module sdm_slave_model (
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic       fault,
	input  wire logic [7:0] tx,
	output logic            miso,
	output logic            sel_n,
	output logic [7:0]      rx,
	output int              n_rx
);
	logic [2:0] fc = 3'h0;
	logic [2:0] rc = 3'h0;
	logic [7:0] sh;
	initial n_rx = 0;
	// select low while the master drives is the fault case
	assign sel_n = ~fault;
	// reply bit ready before the first edge, advances on trailing edges
	assign miso = tx[3'h7 - fc];
	always @(negedge sck or posedge fault) begin
		if (fault) fc <= 3'h0;
		else fc <= fc + 3'h1;
	end
	// capture on leading edges, a byte every eighth
	always @(posedge sck or posedge fault) begin
		if (fault) rc <= 3'h0;
		else begin
			sh <= {sh[6:0], mosi};
			rc <= rc + 3'h1;
			if (rc == 3'h7) rx <= {sh[6:0], mosi};
			if (rc == 3'h7) n_rx <= n_rx + 1;
		end
	end
endmodule

// file: dv/tb.sv
// tb: self-checking bench for sdm_core with a slave model on the pins
// assumes 200 MHz clock; the bench plays link master for slave mode
`timescale 1ns/1ps
module tb;
	localparam logic [7:0] AD = sdm_pkg::ADDR_DATA_IO;
	localparam logic [7:0] AC = sdm_pkg::ADDR_CONTROL;
	localparam logic [7:0] AS = sdm_pkg::ADDR_STATUS;
	logic                 clk, sys_rst, irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
	logic                 fault, p_miso, p_sel_n, msck, mmosi, msel;
	sdm_pkg::sdm_req_t    req;
	wire sdm_pkg::sdm_pin_in_t pin_in;
	logic [7:0]           rdata, v, tx, rx, prev, m, s;
	logic [16:0]          lfsr;
	int                   n_fail, checks, cyc, n_rx, c, k;
	// undriven data line is pulled up
	assign pin_in = '{sck_oe ? sck_o : msck, mosi_oe ? mosi_o : mmosi,
		miso_oe ? miso_o : p_miso, p_sel_n & ~msel};
	sdm_core u_sdm_core (.clk, .sys_rst, .req, .rdata, .irq, .pin_in, .sck_o, .sck_oe,
		.mosi_o, .mosi_oe, .miso_o, .miso_oe);
	sdm_slave_model u_sdm_slave_model (.sck(pin_in.sck), .mosi(pin_in.mosi), .fault, .tx,
		.miso(p_miso), .sel_n(p_sel_n), .rx, .n_rx);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	function automatic logic [16:0] step(input logic [16:0] x);
		return {x[15:0], x[16] ^ x[13]};
	endfunction
	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		#1 v = rdata;
	endtask
	// start a byte, read the buffer mid-flight, wait for the slave's byte
	task xfer(input logic [7:0] d);
		c = n_rx;
		wr(AD, d);
		rd(AD);
		for (int i = 0; i < 400 && n_rx == c; i++) @(posedge clk);
		repeat (12) @(posedge clk);
		chk("xfer_done", 8'(n_rx - c), 8'h01);
	endtask
	task irq_is(input logic e);
		repeat (2) @(posedge clk);
		#1 chk("irq", {7'h0, irq}, {7'h0, e});
	endtask
	task close_out;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// hang guard, far above the less than one thousand cycles the run needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			close_out;
		end
	end
	initial begin
		{fault, msck, msel, mmosi, sys_rst} = 5'h03;
		{tx, prev} = 16'h0000;
		req = '0;
		lfsr = 17'h12637;
		n_fail = 0;
		checks = 0;
		cyc = 0;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		rd(AC); chk("ctl_rst", v & 8'hf0, 8'h00);
		rd(AS); chk("sts_rst", v, 8'h00);
		rd(8'h30); chk("unmapped", v, 8'h00);
		wr(AC, 8'hd0);
		for (k = 0; k < 6; k++) begin
			lfsr = step(lfsr);
			tx = lfsr[7:0];
			m = lfsr[15:8];
			xfer(m);
			if (k > 0) chk("buf_mid", v, prev);
			chk("sent", rx, m);
			irq_is(1'b1);
			rd(AS); chk("done", v, 8'h80);
			rd(AD); chk("recv", v, tx);
			prev = tx;
		end
		wr(AD, 8'h3c);
		xfer(8'hc3); chk("first_kept", rx, 8'h3c);
		c = n_rx;
		wr(AD, 8'h11);
		repeat (100) @(posedge clk);
		chk("ignored", 8'(n_rx - c), 8'h00);
		rd(AS); chk("collide", v, 8'hc0);
		rd(AD); chk("recv2", v, tx);
		wr(AD, 8'h77);
		repeat (10) @(posedge clk);
		fault <= 1'b1;
		repeat (6) @(posedge clk);
		fault <= 1'b0;
		rd(AC); chk("ctl_hw", v & 8'hf0, 8'h80);
		chk("oe_off", {6'h0, sck_oe, mosi_oe}, 8'h00);
		wr(AC, 8'h80);
		rd(AS); chk("fault", v, 8'h10);
		irq_is(1'b1);
		wr(AC, 8'h80);
		rd(AS); chk("fault_clr", v, 8'h00);
		irq_is(1'b0);
		wr(8'h24, 8'h07);
		wr(8'h25, 8'h00);
		wr(AC, 8'h70);
		xfer(8'h0f);
		chk("sent4", rx, 8'h0f);
		irq_is(1'b0);
		rd(8'h24); chk("event", v, 8'h01);
		wr(8'h25, 8'h01);
		irq_is(1'b1);
		wr(8'h24, 8'h01);
		irq_is(1'b0);
		rd(AS);
		rd(AD);
		chk("recv4", v, tx);
		wr(AC, 8'h40);
		wr(AD, 8'h96);
		lfsr = step(lfsr);
		m = lfsr[7:0];
		msel <= 1'b1;
		for (k = 7; k >= 0; k--) begin
			mmosi <= m[k];
			#24 msck <= 1'b1;
			s[k] = miso_o;
			#24 msck <= 1'b0;
		end
		// hold select past the last falling edge, else the slave loses it
		#24 chk("miso_oe", {7'h0, miso_oe}, 8'h01);
		msel <= 1'b0;
		mmosi <= 1'b1;
		repeat (10) @(posedge clk);
		chk("slave_out", s, 8'h96);
		rd(AS); chk("slave_done", v, 8'h80);
		rd(AD); chk("slave_in", v, m);
		close_out;
	end
endmodule
